/* hw/mbpt_pkg.sv */
// Constants, field layout and bus carriers of the match based PWM timer.
package mbpt_pkg;
  // ==========================================================================
  // Sizes
  localparam int MBPT_NMATCH = 7;
  localparam int MBPT_NCAP = 4;
  localparam int MBPT_NPWM = 6;
  localparam int MBPT_AW = 8;
  localparam int MBPT_STAT_W = 12;
  localparam int MBPT_FLD_W = 3;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] MBPT_OFF_STAT = 8'h00;
  localparam logic [7:0] MBPT_OFF_CTRL = 8'h04;
  localparam logic [7:0] MBPT_OFF_COUNT = 8'h08;
  localparam logic [7:0] MBPT_OFF_PRESC = 8'h0C;
  localparam logic [7:0] MBPT_OFF_PCNT = 8'h10;
  localparam logic [7:0] MBPT_OFF_MCTL = 8'h14;
  localparam logic [7:0] MBPT_OFF_MATCH0 = 8'h18;
  localparam logic [7:0] MBPT_OFF_MATCH_LAST = 8'h30;
  localparam logic [7:0] MBPT_OFF_CCTL = 8'h34;
  localparam logic [7:0] MBPT_OFF_CAP0 = 8'h38;
  localparam logic [7:0] MBPT_OFF_CAP_LAST = 8'h44;
  localparam logic [7:0] MBPT_OFF_PWMC = 8'h48;
  localparam logic [7:0] MBPT_OFF_REL = 8'h4C;
  localparam logic [7:0] MBPT_OFF_MASK = 8'h50;
  // ==========================================================================
  // Field positions
  localparam int MBPT_CTRL_EN = 0;
  localparam int MBPT_CTRL_RST = 1;
  localparam int MBPT_CTRL_PWM = 2;
  localparam int MBPT_MCTL_INT = 0;
  localparam int MBPT_MCTL_RST = 1;
  localparam int MBPT_MCTL_STOP = 2;
  localparam int MBPT_CCTL_RISE = 0;
  localparam int MBPT_CCTL_FALL = 1;
  localparam int MBPT_CCTL_INT = 2;
  localparam int MBPT_PWMC_DBL = 0;
  localparam int MBPT_PWMC_ENA = 8;
  localparam int MBPT_STAT_CAP = 8;
  // ==========================================================================
  // Values after reset and bus answers
  localparam logic [31:0] MBPT_RST_VAL = 32'h0000_0000;
  localparam logic [1:0] MBPT_RESP_OKAY = 2'h0;
  localparam logic [1:0] MBPT_RESP_SLVERR = 2'h2;
  // ==========================================================================
  // AXI4-Lite carriers
  typedef struct packed {
    logic [MBPT_AW-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [MBPT_AW-1:0] araddr;
    logic arvalid;
    logic rready;
  } mbpt_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mbpt_axi_rsp_t;
endpackage : mbpt_pkg

/* hw/mbpt_pwm_chan.sv */
// One PWM output stage, driven by set and clear match events.
`timescale 1ns/100ps
module mbpt_pwm_chan
  import mbpt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic dbl,
  input wire logic period_hit,
  input wire logic rise_hit,
  input wire logic fall_hit,
  input wire logic const_low,
  output logic pwm_out
);
  typedef struct packed {
    logic level;
  } mbpt_chan_state_t;

  mbpt_chan_state_t st;
  mbpt_chan_state_t next_st;
  logic set_edge;

  // Clear beats set, so a falling match equal to the rising one yields no pulse.
  always_comb begin
    next_st = st;
    set_edge = dbl ? rise_hit : (period_hit && !const_low);
    if (!enable) begin
      next_st.level = 1'b0;
    end else if (fall_hit) begin
      next_st.level = 1'b0;
    end else if (set_edge) begin
      next_st.level = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pwm_out = st.level;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_single_rise: assert property (
    enable && !dbl && period_hit && !const_low && !fall_hit |=> pwm_out)
    else $error("single edge output did not rise at period match");
  a_const_low: assert property (
    enable && !dbl && const_low && !pwm_out |=> !pwm_out)
    else $error("constant low output went high");
  a_dbl_rise: assert property (
    enable && dbl && rise_hit && !fall_hit |=> pwm_out)
    else $error("double edge output missed its rising match");
  a_fall_edge: assert property (
    enable && fall_hit |=> !pwm_out)
    else $error("output did not fall at its match");
endmodule : mbpt_pwm_chan

/* hw/mbpt_cap_chan.sv */
// One capture input edge detector with selectable edges.
`timescale 1ns/100ps
module mbpt_cap_chan
  import mbpt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic cap_in,
  input wire logic rise_en,
  input wire logic fall_en,
  output logic cap_hit
);
  typedef struct packed {
    logic prev;
  } mbpt_cap_state_t;

  mbpt_cap_state_t st;
  mbpt_cap_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.prev = cap_in;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // The input is already synchronous, so the previous sample is a plain edge reference.
  assign cap_hit = (rise_en && cap_in && !st.prev) || (fall_en && !cap_in && st.prev);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_edge_seen: assert property (
    (rise_en && $rose(cap_in)) or (fall_en && $fell(cap_in)) |-> cap_hit)
    else $error("capture edge not reported");
  a_no_false_edge: assert property (
    $stable(cap_in) |-> !cap_hit)
    else $error("capture reported without an edge");
endmodule : mbpt_cap_chan

/* hw/mbpt_top.sv */
// Match based PWM timer: AXI4-Lite registers, prescaler, counter, matches, captures and outputs.
// Function
// - Counter advances through a programmable 32-bit prescaler; matches trigger actions and interrupts.
// - Seven match registers compare against the counter and produce match events.
// - Four capture inputs store the count on an edge, optionally interrupting.
// - The period match resets the count, fixing the common PWM rate.
// - Single edge output rises at the period match and falls at its own match.
// - Single edge output programmed constant low never rises.
// - Double edge output uses two matches; their order gives pulse polarity.
// - Up to six single, five double edge outputs (outputs 1 to 5), or a mixture.
// - Each match may continue, stop or reset the counter, with optional interrupt.
// - Software releases new match values; they apply only in step with outputs.
// - Period and width are any whole number of timer counts.
// - Without PWM mode the block is a plain timer with outputs low.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module mbpt_top
  import mbpt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input mbpt_axi_req_t axi_req,
  output mbpt_axi_rsp_t axi_rsp,
  input wire logic [MBPT_NCAP-1:0] cap_in,
  output wire logic [MBPT_NPWM-1:0] pwm_out,
  output logic irq
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic aw_held;
    logic [MBPT_AW-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] ctrl;
    logic [31:0] count;
    logic [31:0] presc;
    logic [31:0] pcnt;
    logic [MBPT_FLD_W*MBPT_NMATCH-1:0] mctl;
    logic [MBPT_FLD_W*MBPT_NCAP-1:0] cctl;
    logic [15:0] pwmc;
    logic [MBPT_NMATCH-1:0] rel_pend;
    logic [MBPT_STAT_W-1:0] mask;
    logic [MBPT_STAT_W-1:0] stat;
    logic [MBPT_NMATCH-1:0][31:0] act;
    logic [MBPT_NMATCH-1:0][31:0] shd;
    logic [MBPT_NCAP-1:0][31:0] cap;
    logic irq;
  } mbpt_state_t;

  mbpt_state_t st;
  mbpt_state_t next_st;
  logic tick;
  logic wr_fire;
  logic rst_hit;
  logic stop_hit;
  logic [MBPT_NMATCH-1:0] hit;
  logic [MBPT_NMATCH-1:0] int_hit;
  logic [MBPT_NCAP-1:0] cap_int;
  logic [MBPT_STAT_W-1:0] stat_clr;
  logic [32:0] rd_ar;
  logic [32:0] rd_aw;
  logic [31:0] wv;
  logic [31:0] wdm;
  logic [2:0] wmi;
  wire [MBPT_NCAP-1:0] cap_hit;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] mbpt_merge(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction : mbpt_merge

  function automatic logic mbpt_in_match(input logic [MBPT_AW-1:0] a);
    return (a >= MBPT_OFF_MATCH0) && (a <= MBPT_OFF_MATCH_LAST) && (a[1:0] == 2'h0);
  endfunction : mbpt_in_match

  // Bit 32 of the result flags an unmapped or unaligned address.
  function automatic logic [32:0] mbpt_read(input mbpt_state_t s, input logic [MBPT_AW-1:0] a);
    logic [32:0] res;
    logic [2:0] mi;
    logic [1:0] ci;
    res = {1'b0, MBPT_RST_VAL};
    mi = 3'((a - MBPT_OFF_MATCH0) >> 2);
    ci = 2'((a - MBPT_OFF_CAP0) >> 2);
    case (a)
      MBPT_OFF_STAT: res[31:0] = 32'(s.stat);
      MBPT_OFF_CTRL: res[31:0] = 32'(s.ctrl);
      MBPT_OFF_COUNT: res[31:0] = s.count;
      MBPT_OFF_PRESC: res[31:0] = s.presc;
      MBPT_OFF_PCNT: res[31:0] = s.pcnt;
      MBPT_OFF_MCTL: res[31:0] = 32'(s.mctl);
      MBPT_OFF_CCTL: res[31:0] = 32'(s.cctl);
      MBPT_OFF_PWMC: res[31:0] = 32'(s.pwmc);
      MBPT_OFF_REL: res[31:0] = 32'(s.rel_pend);
      MBPT_OFF_MASK: res[31:0] = 32'(s.mask);
      default: begin
        if (mbpt_in_match(a)) begin
          res[31:0] = s.shd[mi];
        end else if ((a >= MBPT_OFF_CAP0) && (a <= MBPT_OFF_CAP_LAST) && (a[1:0] == 2'h0)) begin
          res[31:0] = s.cap[ci];
        end else begin
          res[32] = 1'b1;
        end
      end
    endcase
    return res;
  endfunction : mbpt_read

  // ==========================================================================
  // Next state
  always_comb begin
    next_st = st;
    stat_clr = '0;
    rd_ar = mbpt_read(st, axi_req.araddr);
    rd_aw = mbpt_read(st, st.aw_addr);
    wv = mbpt_merge(rd_aw[31:0], st.w_data, st.w_strb);
    wdm = mbpt_merge(MBPT_RST_VAL, st.w_data, st.w_strb);
    wmi = 3'((st.aw_addr - MBPT_OFF_MATCH0) >> 2);
    wr_fire = st.aw_held && st.w_held && !st.bvalid;

    // Bus channels; address and data may arrive in either order.
    if (axi_req.awvalid && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.w_data = axi_req.wdata;
      next_st.w_strb = axi_req.wstrb;
    end
    if (st.bvalid && axi_req.bready) begin
      next_st.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = rd_aw[32] ? MBPT_RESP_SLVERR : MBPT_RESP_OKAY;
    end
    if (st.rvalid && axi_req.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_ar[31:0];
      next_st.rresp = rd_ar[32] ? MBPT_RESP_SLVERR : MBPT_RESP_OKAY;
    end

    // One count per prescaler wrap; each match fires once per count value.
    tick = st.ctrl[MBPT_CTRL_EN] && !st.ctrl[MBPT_CTRL_RST] && (st.pcnt == st.presc);
    rst_hit = 1'b0;
    stop_hit = 1'b0;
    for (int i = 0; i < MBPT_NMATCH; i++) begin
      hit[i] = tick && (st.count == st.act[i]);
      int_hit[i] = hit[i] && st.mctl[MBPT_FLD_W*i+MBPT_MCTL_INT];
      rst_hit = rst_hit || (hit[i] && st.mctl[MBPT_FLD_W*i+MBPT_MCTL_RST]);
      stop_hit = stop_hit || (hit[i] && st.mctl[MBPT_FLD_W*i+MBPT_MCTL_STOP]);
    end
    if (st.ctrl[MBPT_CTRL_RST]) begin
      next_st.count = MBPT_RST_VAL;
      next_st.pcnt = MBPT_RST_VAL;
    end else if (st.ctrl[MBPT_CTRL_EN]) begin
      if (tick) begin
        next_st.pcnt = MBPT_RST_VAL;
        next_st.count = rst_hit ? MBPT_RST_VAL : st.count + 32'h0000_0001;
      end else begin
        next_st.pcnt = st.pcnt + 32'h0000_0001;
      end
    end
    if (stop_hit) begin
      next_st.ctrl[MBPT_CTRL_EN] = 1'b0;
    end

    // Captures hold the count seen in the cycle of the edge.
    for (int c = 0; c < MBPT_NCAP; c++) begin
      cap_int[c] = cap_hit[c] && st.cctl[MBPT_FLD_W*c+MBPT_CCTL_INT];
      if (cap_hit[c]) begin
        next_st.cap[c] = st.count;
      end
    end

    // Edges must not move mid-cycle, so released values wait for the period match.
    if (hit[0] && st.ctrl[MBPT_CTRL_PWM]) begin
      for (int i = 0; i < MBPT_NMATCH; i++) begin
        if (st.rel_pend[i]) begin
          next_st.act[i] = st.shd[i];
        end
      end
      next_st.rel_pend = '0;
    end

    // Software writes land after the hardware step; release bits only ever set here.
    if (wr_fire) begin
      case (st.aw_addr)
        MBPT_OFF_STAT: stat_clr = wdm[MBPT_STAT_W-1:0];
        MBPT_OFF_CTRL: next_st.ctrl = wv[2:0];
        MBPT_OFF_COUNT: next_st.count = wv;
        MBPT_OFF_PRESC: next_st.presc = wv;
        MBPT_OFF_PCNT: next_st.pcnt = wv;
        MBPT_OFF_MCTL: next_st.mctl = wv[MBPT_FLD_W*MBPT_NMATCH-1:0];
        MBPT_OFF_CCTL: next_st.cctl = wv[MBPT_FLD_W*MBPT_NCAP-1:0];
        MBPT_OFF_PWMC: next_st.pwmc = wv[15:0];
        MBPT_OFF_REL: next_st.rel_pend = next_st.rel_pend | wdm[MBPT_NMATCH-1:0];
        MBPT_OFF_MASK: next_st.mask = wv[MBPT_STAT_W-1:0];
        default: begin
          if (mbpt_in_match(st.aw_addr)) begin
            next_st.shd[wmi] = wv;
            if (!st.ctrl[MBPT_CTRL_PWM]) begin
              next_st.act[wmi] = wv;
            end
          end
        end
      endcase
    end

    // A new event in the cycle of its clear stays set.
    next_st.stat = (st.stat & ~stat_clr) | {cap_int, 1'b0, int_hit};
    next_st.irq = |(next_st.stat & next_st.mask);
  end

  // All control state clears to zero at reset.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign irq = st.irq;
  assign axi_rsp = '{awready: !st.aw_held, wready: !st.w_held, bvalid: st.bvalid, bresp: st.bresp,
                     arready: !st.rvalid, rvalid: st.rvalid, rdata: st.rdata, rresp: st.rresp};

  // ==========================================================================
  // Output and capture channels
  // Output g falls at match g+1; it rises at the period match, or at match g when double edged.
  for (genvar g = 0; g < MBPT_NPWM; g++) begin : g_pwm
    mbpt_pwm_chan u_chan (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .enable(st.ctrl[MBPT_CTRL_PWM] && st.pwmc[MBPT_PWMC_ENA+g]),
      .dbl((g != 0) && st.pwmc[MBPT_PWMC_DBL+g]),
      .period_hit(hit[0]),
      .rise_hit(hit[g]),
      .fall_hit(hit[g+1]),
      .const_low(st.act[g+1] == MBPT_RST_VAL),
      .pwm_out(pwm_out[g])
    );
  end

  for (genvar c = 0; c < MBPT_NCAP; c++) begin : g_cap
    mbpt_cap_chan u_cap (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .cap_in(cap_in[c]),
      .rise_en(st.cctl[MBPT_FLD_W*c+MBPT_CCTL_RISE]),
      .fall_en(st.cctl[MBPT_FLD_W*c+MBPT_CCTL_FALL]),
      .cap_hit(cap_hit[c])
    );
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_write_pair;
    st.aw_held && st.w_held && !st.bvalid;
  endsequence
  sequence s_release;
    st.ctrl[MBPT_CTRL_PWM] && st.rel_pend[1] && hit[0] && !wr_fire;
  endsequence

  a_write_resp: assert property (s_write_pair |=> axi_rsp.bvalid ##0 !st.aw_held)
    else $error("write response missing");
  a_read_resp: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read answer missing");
  a_count_step: assert property (
    tick && !rst_hit && !wr_fire |=> st.count == $past(st.count) + 32'h0000_0001)
    else $error("counter did not advance on prescaler wrap");
  a_presc_step: assert property (
    st.ctrl[MBPT_CTRL_EN] && !st.ctrl[MBPT_CTRL_RST] && !tick && !wr_fire
    |=> st.pcnt == $past(st.pcnt) + 32'h0000_0001)
    else $error("prescaler did not advance");
  a_match_int: assert property (
    hit[1] && st.mctl[MBPT_FLD_W*1+MBPT_MCTL_INT] |=> st.stat[1] ##1 st.stat[1] || $past(wr_fire))
    else $error("match interrupt flag not set");
  a_period_reset: assert property (
    hit[0] && st.mctl[MBPT_MCTL_RST] && !wr_fire |=> st.count == MBPT_RST_VAL)
    else $error("period match did not restart the count");
  a_stop_match: assert property (
    stop_hit && !wr_fire |=> !st.ctrl[MBPT_CTRL_EN] ##1 $stable(st.count))
    else $error("stop on match did not halt the counter");
  a_cap_store: assert property (
    cap_hit[0] |=> st.cap[0] == $past(st.count))
    else $error("capture did not store the count");
  a_release_apply: assert property (
    s_release |=> st.act[1] == $past(st.shd[1]) && !st.rel_pend[1])
    else $error("released match not applied at period match");
  a_hold_unrel: assert property (
    st.ctrl[MBPT_CTRL_PWM] && !st.rel_pend[3] && !wr_fire |=> $stable(st.act[3]))
    else $error("active match changed without release");
  a_timer_mode: assert property (
    !st.ctrl[MBPT_CTRL_PWM] |=> pwm_out == '0)
    else $error("output active outside PWM mode");
endmodule : mbpt_top

/* dv/mbpt_load_model.sv */
// Load model at the PWM pins and driver of the capture inputs.
`timescale 1ns/100ps
module mbpt_load_model
  import mbpt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [MBPT_NPWM-1:0] pwm_out,
  output logic [MBPT_NCAP-1:0] cap_in
);
  // ==========================================================================
  // Pulse measurement
  logic [31:0] run [MBPT_NPWM];
  logic [31:0] hi_len [MBPT_NPWM];
  logic [31:0] lo_len [MBPT_NPWM];
  logic [31:0] rises [MBPT_NPWM];
  logic [MBPT_NPWM-1:0] last;
  initial cap_in = '0;
  // A length is only recorded at the edge that ends it, so a partial first pulse is overwritten later.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      last <= '0;
      for (int g = 0; g < MBPT_NPWM; g++) begin
        run[g] <= 32'h0000_0000;
        hi_len[g] <= 32'h0000_0000;
        lo_len[g] <= 32'h0000_0000;
        rises[g] <= 32'h0000_0000;
      end
    end else begin
      for (int g = 0; g < MBPT_NPWM; g++) begin
        if (pwm_out[g] !== last[g]) begin
          if (last[g]) hi_len[g] <= run[g];
          else lo_len[g] <= run[g];
          if (pwm_out[g] === 1'b1) rises[g] <= rises[g] + 32'h0000_0001;
          run[g] <= 32'h0000_0001;
        end else begin
          run[g] <= run[g] + 32'h0000_0001;
        end
        last[g] <= pwm_out[g];
      end
    end
  end
  // ==========================================================================
  // Capture pulse
  task automatic pulse_cap(input int c, input int len);
    @(posedge clk_sys);
    cap_in[c] <= 1'b1;
    repeat (len) @(posedge clk_sys);
    cap_in[c] <= 1'b0;
  endtask : pulse_cap
endmodule : mbpt_load_model

/* dv/tb_top.sv */
// Register level testbench of the match based PWM timer.
`timescale 1ns/100ps
module tb_top
  import mbpt_pkg::*;
();
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  mbpt_axi_req_t req = '0;
  mbpt_axi_rsp_t rsp;
  logic [MBPT_NCAP-1:0] cap_in;
  logic [MBPT_NPWM-1:0] pwm_out;
  logic irq;
  logic [31:0] rdv;
  logic [1:0] rs;
  int num_errors = 0;
  int checks_done = 0;
  int n;
  always #4 clk_sys = ~clk_sys;
  mbpt_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .axi_req(req), .axi_rsp(rsp), .cap_in(cap_in),
    .pwm_out(pwm_out), .irq(irq));
  mbpt_load_model u_load (.clk_sys(clk_sys), .rst_b(rst_b), .pwm_out(pwm_out), .cap_in(cap_in));
  // ==========================================================================
  // Bus tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Handshakes are judged at the rising edge that completes them, from the values the slave samples there.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic b_hit;
    b_hit = 1'b0;
    @(posedge clk_sys);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!b_hit) begin
      @(posedge clk_sys);
      b_hit = (rsp.bvalid === 1'b1);
      rs = rsp.bresp;
      if (req.awvalid && (rsp.awready === 1'b1)) req.awvalid <= 1'b0;
      if (req.wvalid && (rsp.wready === 1'b1)) req.wvalid <= 1'b0;
    end
    req.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic r_hit;
    r_hit = 1'b0;
    @(posedge clk_sys);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    while (!r_hit) begin
      @(posedge clk_sys);
      r_hit = (rsp.rvalid === 1'b1);
      rdv = rsp.rdata;
      rs = rsp.rresp;
      if (req.arvalid && (rsp.arready === 1'b1)) req.arvalid <= 1'b0;
    end
    req.rready <= 1'b0;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    rd(a);
    check(what, rdv, exp);
  endtask : rchk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  // ==========================================================================
  // Tests
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    rchk(MBPT_OFF_CTRL, 32'h0000_0000, "ctrl_reset");
    check("read_okay", {30'h0, rs}, {30'h0, MBPT_RESP_OKAY});
    check("irq_reset", {31'h0, irq}, 32'h0000_0000);
    rd(8'h54);
    check("unmapped_read", {30'h0, rs}, {30'h0, MBPT_RESP_SLVERR});
    wr(8'h54, 32'h0000_FFFF);
    check("unmapped_write", {30'h0, rs}, {30'h0, MBPT_RESP_SLVERR});
    $display("test reset_map done");
    // Counting starts at 1 so that the zero matches never hit before the stop.
    wr(MBPT_OFF_MCTL, 32'h0000_0028);
    check("write_okay", {30'h0, rs}, {30'h0, MBPT_RESP_OKAY});
    wr(MBPT_OFF_MATCH0 + 8'h04, 32'h0000_000A);
    wr(MBPT_OFF_COUNT, 32'h0000_0001);
    wr(MBPT_OFF_PRESC, 32'h0000_0001);
    wr(MBPT_OFF_MASK, 32'h0000_0002);
    wr(MBPT_OFF_CTRL, 32'h0000_0001);
    for (n = 0; n < 200 && irq !== 1'b1; n++) @(negedge clk_sys);
    check("stop_delay", {31'h0, n >= 18 && n <= 26}, 32'h0000_0001);
    rchk(MBPT_OFF_COUNT, 32'h0000_000B, "count_stop");
    rchk(MBPT_OFF_CTRL, 32'h0000_0000, "enable_cleared");
    rchk(MBPT_OFF_STAT, 32'h0000_0002, "match1_stat");
    wr(MBPT_OFF_MASK, 32'h0000_0000);
    repeat (3) @(posedge clk_sys);
    check("irq_masked", {31'h0, irq}, 32'h0000_0000);
    wr(MBPT_OFF_MASK, 32'h0000_0002);
    repeat (3) @(posedge clk_sys);
    check("irq_unmasked", {31'h0, irq}, 32'h0000_0001);
    wr(MBPT_OFF_STAT, 32'h0000_0002);
    repeat (3) @(posedge clk_sys);
    check("irq_cleared", {31'h0, irq}, 32'h0000_0000);
    rchk(MBPT_OFF_STAT, 32'h0000_0000, "stat_cleared");
    $display("test stop_irq done");
    wr(MBPT_OFF_MCTL, 32'h0000_0002);
    wr(MBPT_OFF_MATCH0, 32'h0000_0004);
    wr(MBPT_OFF_COUNT, 32'h0000_0000);
    wr(MBPT_OFF_PRESC, 32'h0000_0000);
    wr(MBPT_OFF_CTRL, 32'h0000_0001);
    for (n = 0; n < 6; n++) begin
      rd(MBPT_OFF_COUNT);
      check("count_in_period", {31'h0, rdv <= 32'h0000_0004}, 32'h0000_0001);
      check("pwm_off", {26'h0, pwm_out}, 32'h0000_0000);
    end
    $display("test period_reset done");
    // Output 0 single edge, output 1 constant low, output 3 double edge on matches 3 and 4.
    wr(MBPT_OFF_CTRL, 32'h0000_0000);
    wr(MBPT_OFF_COUNT, 32'h0000_0000);
    wr(MBPT_OFF_MATCH0, 32'h0000_0007);
    wr(MBPT_OFF_MATCH0 + 8'h04, 32'h0000_0002);
    wr(MBPT_OFF_MATCH0 + 8'h08, 32'h0000_0000);
    wr(MBPT_OFF_MATCH0 + 8'h0C, 32'h0000_0002);
    wr(MBPT_OFF_MATCH0 + 8'h10, 32'h0000_0005);
    wr(MBPT_OFF_PWMC, 32'h0000_0B08);
    wr(MBPT_OFF_CTRL, 32'h0000_0005);
    repeat (60) @(posedge clk_sys);
    check("out0_high", u_load.hi_len[0], 32'h0000_0003);
    check("out0_low", u_load.lo_len[0], 32'h0000_0005);
    check("out3_high", u_load.hi_len[3], 32'h0000_0003);
    check("out3_low", u_load.lo_len[3], 32'h0000_0005);
    check("out1_rises", u_load.rises[1], 32'h0000_0000);
    wr(MBPT_OFF_MATCH0 + 8'h04, 32'h0000_0004);
    wr(MBPT_OFF_MATCH0 + 8'h0C, 32'h0000_0005);
    wr(MBPT_OFF_MATCH0 + 8'h10, 32'h0000_0002);
    repeat (40) @(posedge clk_sys);
    check("out0_unreleased", u_load.hi_len[0], 32'h0000_0003);
    check("out3_unreleased", u_load.hi_len[3], 32'h0000_0003);
    wr(MBPT_OFF_REL, 32'h0000_001A);
    repeat (40) @(posedge clk_sys);
    check("out0_high_new", u_load.hi_len[0], 32'h0000_0005);
    check("out0_low_new", u_load.lo_len[0], 32'h0000_0003);
    check("out3_neg_high", u_load.hi_len[3], 32'h0000_0005);
    check("out3_neg_low", u_load.lo_len[3], 32'h0000_0003);
    rchk(MBPT_OFF_REL, 32'h0000_0000, "rel_cleared");
    check("out1_rises_end", u_load.rises[1], 32'h0000_0000);
    $display("test pwm done");
    wr(MBPT_OFF_CTRL, 32'h0000_0000);
    wr(MBPT_OFF_COUNT, 32'h0000_1234);
    wr(MBPT_OFF_CCTL, 32'h0000_0015);
    wr(MBPT_OFF_MASK, 32'h0000_0100);
    u_load.pulse_cap(0, 3);
    repeat (2) @(posedge clk_sys);
    wr(MBPT_OFF_COUNT, 32'h0000_5678);
    u_load.pulse_cap(1, 3);
    repeat (2) @(posedge clk_sys);
    rchk(MBPT_OFF_CAP0, 32'h0000_1234, "cap0_rise");
    rchk(MBPT_OFF_CAP0 + 8'h04, 32'h0000_5678, "cap1_fall");
    rchk(MBPT_OFF_CAP0 + 8'h08, 32'h0000_0000, "cap2_idle");
    rchk(MBPT_OFF_STAT, 32'h0000_0100, "cap_stat");
    check("cap_irq", {31'h0, irq}, 32'h0000_0001);
    $display("test capture done");
    print_verdict();
  end
  // ==========================================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule : tb_top
